/* File: ssl_pkg.sv */
package ssl_pkg;
    localparam int          WORD_BITS    = 12;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          CLK_DIV      = 4;
    localparam int          DIV_W        = 3;
    localparam logic [2:0]  DIV_LAST     = 3'h3;
    localparam logic [3:0]  BIT_LAST     = 4'hB;
    localparam logic [11:0] LATCH_RESET  = 12'h000;
endpackage : ssl_pkg

/* File: ssl_link_if.sv */
`timescale 1ns/1ps
interface ssl_link_if;
    logic shift_clk;
    logic serial_in;
    logic latch_strobe;
    logic serial_out;

    modport host (
        output shift_clk,
        output serial_in,
        output latch_strobe,
        input  serial_out
    );
    modport dev (
        input  shift_clk,
        input  serial_in,
        input  latch_strobe,
        output serial_out
    );
endinterface : ssl_link_if

/* File: ssl_fifo.sv */
`timescale 1ns/1ps
module ssl_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ssl_fifo_s;

    ssl_fifo_s             s_q;
    ssl_fifo_s             s_d;
    logic [WIDTH-1:0]      mem [DEPTH];
    logic                  push;
    logic                  pop;

    assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_q.cnt != '0;
    assign out_data  = mem[s_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[s_q.wp] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ssl_fifo

/* File: ssl_host.sv */
`timescale 1ns/1ps
module ssl_host (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [11:0] word_data,
    input  wire logic        word_valid,
    output logic             word_ready,
    output logic             busy,
    ssl_link_if.host         link
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOW, ST_HIGH, ST_STROBE_HI, ST_STROBE_LO
    } ssl_host_e;

    typedef struct packed {
        ssl_host_e   st;
        logic [2:0]  div;
        logic [3:0]  bitn;
        logic [11:0] sh;
        logic        sck;
        logic        sdo;
        logic        ld;
        logic        pop;
    } ssl_host_s;

    ssl_host_s   s_q;
    ssl_host_s   s_d;
    logic [11:0] f_data;
    logic        f_valid;
    logic        tick;

    ssl_fifo #(.WIDTH(ssl_pkg::WORD_BITS), .DEPTH(ssl_pkg::FIFO_DEPTH)) u_ssl_fifo (
        .clock    (clock),
        .resetn   (resetn),
        .in_data  (word_data),
        .in_valid (word_valid),
        .in_ready (word_ready),
        .out_data (f_data),
        .out_valid(f_valid),
        .out_ready(s_q.pop)
    );

    assign tick              = s_q.div == ssl_pkg::DIV_LAST;
    assign link.shift_clk    = s_q.sck;
    assign link.serial_in    = s_q.sdo;
    assign link.latch_strobe = s_q.ld;
    assign busy              = s_q.st != ST_IDLE;

    always_comb begin
        s_d     = s_q;
        s_d.pop = 1'b0;
        s_d.div = tick ? 3'h0 : s_q.div + 3'h1;
        case (s_q.st)
            ST_IDLE: begin
                s_d.sck = 1'b0;
                s_d.div = 3'h0;
                if (f_valid && !s_q.pop) begin
                    s_d.sh   = f_data;
                    s_d.pop  = 1'b1;
                    s_d.bitn = 4'h0;
                    s_d.sdo  = f_data[11];
                    s_d.st   = ST_LOW;
                end
            end
            ST_LOW: if (tick) begin
                s_d.sck = 1'b1;
                s_d.st  = ST_HIGH;
            end
            ST_HIGH: if (tick) begin
                s_d.sck = 1'b0;
                if (s_q.bitn == ssl_pkg::BIT_LAST) begin
                    s_d.st = ST_STROBE_HI;
                end else begin
                    s_d.sh   = {s_q.sh[10:0], 1'b0};
                    s_d.sdo  = s_q.sh[10];
                    s_d.bitn = s_q.bitn + 4'h1;
                    s_d.st   = ST_LOW;
                end
            end
            ST_STROBE_HI: if (tick) begin
                s_d.ld = 1'b1;
                s_d.st = ST_STROBE_LO;
            end
            ST_STROBE_LO: if (tick) begin
                s_d.ld = 1'b0;
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q    <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ssl_host

/* File: ssl_device.sv */
`timescale 1ns/1ps
module ssl_device (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        blank,
    output logic      [11:0] driver_outputs,
    output logic      [11:0] latch_view,
    ssl_link_if.dev          link
);
    typedef struct packed {
        logic [1:0]  sck_s;
        logic [1:0]  sdi_s;
        logic [1:0]  ld_s;
        logic        sck_p;
        logic        ld_p;
        logic [11:0] sreg;
        logic [11:0] latch;
        logic        sout;
        logic [11:0] outs;
    } ssl_dev_s;

    ssl_dev_s s_q;
    ssl_dev_s s_d;
    logic     sck_rise;
    logic     sck_fall;
    logic     ld_fall;

    assign sck_rise       = s_q.sck_s[1] && !s_q.sck_p;
    assign sck_fall       = !s_q.sck_s[1] && s_q.sck_p;
    assign ld_fall        = !s_q.ld_s[1] && s_q.ld_p;
    assign link.serial_out = s_q.sout;
    assign driver_outputs = s_q.outs;
    assign latch_view     = s_q.latch;

    always_comb begin
        s_d       = s_q;
        s_d.sck_s = {s_q.sck_s[0], link.shift_clk};
        s_d.sdi_s = {s_q.sdi_s[0], link.serial_in};
        s_d.ld_s  = {s_q.ld_s[0], link.latch_strobe};
        s_d.sck_p = s_q.sck_s[1];
        s_d.ld_p  = s_q.ld_s[1];
        if (sck_rise) begin
            s_d.sreg = {s_q.sreg[10:0], s_q.sdi_s[1]};
        end
        if (sck_fall) begin
            s_d.sout = s_q.sreg[11];
        end
        if (s_q.ld_s[1] || ld_fall) begin
            s_d.latch = s_q.sreg;
        end
        s_d.outs = s_q.latch;
        if (blank) begin
            s_d.outs = ssl_pkg::LATCH_RESET;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : ssl_device

/* File: ssl_link_sva.sv */
`timescale 1ns/1ps
module ssl_link_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic latch_strobe,
    input wire logic serial_out
);
    logic [3:0] rises_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Shift clock rises since last capture
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rises_q <= 4'h0;
        else if ($fell(latch_strobe)) rises_q <= 4'h0;
        else if ($rose(shift_clk)) rises_q <= rises_q + 4'h1;
    end
    a_reset_quiet: assert property ($rose(resetn) |-> !shift_clk && !latch_strobe && !serial_out)
        else $error("link not quiet after reset");
    a_high_half: assert property ($rose(shift_clk) |-> shift_clk[*4] ##1 !shift_clk)
        else $error("shift clock high phase wrong");
    a_low_half: assert property ($fell(shift_clk) |-> !shift_clk[*4])
        else $error("shift clock low phase short");
    a_data_steady: assert property (shift_clk |-> $stable(serial_in))
        else $error("serial data moved while clock high");
    a_word_length: assert property ($rose(latch_strobe) |-> rises_q == 4'hC)
        else $error("capture not after twelve bits");
    a_strobe_width: assert property ($rose(latch_strobe) |-> latch_strobe[*4] ##1 !latch_strobe)
        else $error("strobe pulse width wrong");
    a_strobe_no_clk: assert property (latch_strobe |-> !shift_clk)
        else $error("shift clock high during strobe");
    a_out_on_low: assert property ($changed(serial_out) |-> !shift_clk)
        else $error("serial output moved while clock high");
    cover property ($fell(latch_strobe));
    cover property ($changed(serial_out));
    cover property (rises_q == 4'hC);
endmodule : ssl_link_sva

/* File: serial_shift_latch_driver_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: got %h", $time, a); end end
module serial_shift_latch_driver_test;
    logic        clock, resetn, blank, word_valid, word_ready, busy, saw_full;
    logic [11:0] word_data, driver_outputs, latch_view;
    int          error_cnt, compares;
    ssl_link_if link ();
    ssl_host u_ssl_host (.clock(clock), .resetn(resetn), .word_data(word_data), .word_valid(word_valid),
        .word_ready(word_ready), .busy(busy), .link(link.host));
    ssl_device u_ssl_device (.clock(clock), .resetn(resetn), .blank(blank), .driver_outputs(driver_outputs),
        .latch_view(latch_view), .link(link.dev));
    ssl_link_sva u_ssl_link_sva (.clock(clock), .resetn(resetn), .shift_clk(link.shift_clk),
        .serial_in(link.serial_in), .latch_strobe(link.latch_strobe), .serial_out(link.serial_out));
    task automatic push(input logic [11:0] w);
        @(negedge clock);
        word_data = w;
        word_valid = 1'b1;
        while (!word_ready) begin
            saw_full = 1'b1;
            @(negedge clock);
        end
        @(negedge clock);
        word_valid = 1'b0;
    endtask : push
    task automatic settle();
        int idle;
        idle = 0;
        while (idle < 20) begin
            @(negedge clock);
            idle = busy ? 0 : idle + 1;
        end
    endtask : settle
    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0; blank = 1'b0; word_valid = 1'b0; word_data = 12'h000;
        saw_full = 1'b0; error_cnt = 0; compares = 0;
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        `CHK(driver_outputs, 12'h000)
        `CHK(link.serial_out, 1'b0)
        push(12'hA5C);
        wait (link.latch_strobe);
        repeat (4) @(negedge clock);
        `CHK(link.latch_strobe, 1'b1)
        `CHK(latch_view, 12'hA5C)
        settle();
        `CHK(latch_view, 12'hA5C)
        `CHK(driver_outputs, 12'hA5C)
        push(12'h3F0);
        push(12'hC0F);
        settle();
        `CHK(driver_outputs, 12'hC0F)
        `CHK(link.serial_out, 1'b1)
        blank = 1'b1;
        repeat (2) @(negedge clock);
        `CHK(driver_outputs, 12'h000)
        `CHK(latch_view, 12'hC0F)
        blank = 1'b0;
        repeat (2) @(negedge clock);
        `CHK(driver_outputs, 12'hC0F)
        resetn = 1'b0;
        @(negedge clock);
        `CHK(latch_view, 12'h000)
        `CHK(driver_outputs, 12'h000)
        `CHK(link.serial_out, 1'b0)
        resetn = 1'b1;
        @(negedge clock);
        for (int i = 0; i < 18; i++) push(12'h5A0 + 12'(i));
        settle();
        `CHK(saw_full, 1'b1)
        `CHK(latch_view, 12'h5B1)
        `CHK(link.serial_out, 1'b0)
        wrap_up();
    end
endmodule : serial_shift_latch_driver_test
